// *** hdl/tcpr_axil_slave.sv ***
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: full word accesses only
// Notes: unmapped addresses answer SLVERR, writes to them are dropped
`default_nettype none
module tcpr_axil_slave
	import tcpr_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// write address and data
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// register side
	output tcpr_wr_type wrReq,
	output logic [ADDR_WIDTH-1:0] rdAddr,
	input wire logic [31:0] rdData,
	input wire logic rdHit
);
	logic haveAw_r;
	logic haveW_r;
	logic [ADDR_WIDTH-1:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic doWrite;
	logic wrHit;
	logic haveAw_nxt;
	logic haveW_nxt;
	logic bValid_nxt;
	logic rValid_nxt;

	assign doWrite = haveAw_r && haveW_r && !s_axi_bvalid;
	assign rdAddr = s_axi_araddr;

	// next handshake state, so the ready lines can leave a flop with unchanged timing
	assign haveAw_nxt = (s_axi_awvalid && s_axi_awready) || (haveAw_r && !doWrite);
	assign haveW_nxt = (s_axi_wvalid && s_axi_wready) || (haveW_r && !doWrite);
	assign bValid_nxt = doWrite || (s_axi_bvalid && !s_axi_bready);
	assign rValid_nxt = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);

	// registered ready lines, high out of reset
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_arready <= 1'b1;
		end else begin
			s_axi_awready <= !haveAw_nxt && !bValid_nxt;
			s_axi_wready <= !haveW_nxt && !bValid_nxt;
			s_axi_arready <= !rValid_nxt;
		end
	end

	// capture address and data in either order
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			haveAw_r <= 1'b0;
			haveW_r <= 1'b0;
			awAddr_r <= '0;
			wData_r <= RST_WORD;
			wStrb_r <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				haveAw_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end else if (doWrite)
				haveAw_r <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) begin
				haveW_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end else if (doWrite)
				haveW_r <= 1'b0;
		end
	end

	// partial strobes are refused: only word writes are supported
	always_comb begin
		wrReq = '0;
		wrReq.data = wData_r;
		if (doWrite && wStrb_r == 4'hF) begin
			wrReq.wrCount = (awAddr_r == OFS_COUNT);
			wrReq.wrDivider = (awAddr_r == OFS_DIVIDER);
			wrReq.wrReload = (awAddr_r == OFS_RELOAD);
			wrReq.wrControl = (awAddr_r == OFS_CONTROL);
		end
	end
	assign wrHit = wrReq.wrCount || wrReq.wrDivider || wrReq.wrReload || wrReq.wrControl;

	// write response
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// read response, one cycle after address
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= RST_WORD;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdHit ? rdData : RST_WORD;
			s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule : tcpr_axil_slave // tcpr_axil_slave
`default_nettype wire

// *** hdl/tcpr_pkg.sv ***
// Purpose: shared constants and carriers for the timer counting core
// Assumes: 32-bit AXI4-Lite register bus, word aligned registers
// Notes: offsets are byte addresses
`default_nettype none
package tcpr_pkg;
	localparam logic [7:0] OFS_COUNT = 8'h24;
	localparam logic [7:0] OFS_DIVIDER = 8'h28;
	localparam logic [7:0] OFS_RELOAD = 8'h2C;
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam int DIV_WIDTH = 16;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam int CTRL_EN_BIT = 0;
	localparam int ADDR_WIDTH = 8;

	// one register write leaving the bus slave
	typedef struct packed {
		logic wrCount;
		logic wrDivider;
		logic wrReload;
		logic wrControl;
		logic [31:0] data;
	} tcpr_wr_type;
endpackage : tcpr_pkg
`default_nettype wire

// *** hdl/tcpr_prescaler.sv ***
// Purpose: divides the input clock into a count tick by shadowed setting plus one
// Assumes: shadow reloads only on update events
// Notes: setting zero ticks every cycle
`default_nettype none
module tcpr_prescaler
	import tcpr_pkg::*;
#(
	parameter int WIDTH = DIV_WIDTH
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// control
	input wire logic run,
	input wire logic [WIDTH-1:0] divideSetting,
	input wire logic updateEvent,
	// output
	output logic tick,
	output logic [WIDTH-1:0] shadowSetting
);
	logic [WIDTH-1:0] divCount_r;

	// shadow copy, loaded only on update so a write never glitches a running period
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			shadowSetting <= '0;
		else if (updateEvent)
			shadowSetting <= divideSetting;
	end

	// divide by shadow plus one; restart the period on update
	always_ff @(posedge ref_clk) begin
		if (sys_rst || updateEvent || !run)
			divCount_r <= '0;
		else if (divCount_r >= shadowSetting)
			divCount_r <= '0;
		else
			divCount_r <= divCount_r + 1'b1;
	end

	assign tick = run && (divCount_r >= shadowSetting);
endmodule : tcpr_prescaler // tcpr_prescaler
`default_nettype wire

// *** hdl/tcpr_timer_core.sv ***
// Purpose: timer counting core with prescaler, auto-reload and live count register
// Assumes: AXI4-Lite word access, single clock, synchronous reset
// Notes: WIDE selects the 32-bit variant, else a 16-bit counter
//
// Register access over AXI4-Lite was decided locally.
`default_nettype none
// Operation
// - count reads live, writes overwrite immediately
// - narrow variant: 16 bits, upper reads zero
// - counter ticks at input clock over setting+1
// - divider uses shadow loaded on update event
// - wide variant has 32-bit reload value
module tcpr_timer_core
	import tcpr_pkg::*;
#(
	parameter bit WIDE = 1'b1
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// axi4-lite write
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// status
	output logic updatePulse,
	output logic [31:0] liveCount
);
	localparam int CW = WIDE ? 32 : 16;

	tcpr_wr_type wrReq;
	logic [ADDR_WIDTH-1:0] rdAddr;
	logic [31:0] rdData;
	logic rdHit;
	logic awReadyC;
	logic wReadyC;
	logic arReadyC;
	logic [CW-1:0] count_r;
	logic [CW-1:0] count_nxt;
	logic [CW-1:0] reload_r;
	logic [DIV_WIDTH-1:0] divideSetting_r;
	logic [DIV_WIDTH-1:0] shadowSetting;
	logic run_r;
	logic tick;
	logic updateEvent;

	tcpr_axil_slave u_bus (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(awReadyC),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(wReadyC),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(arReadyC),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wrReq(wrReq),
		.rdAddr(rdAddr),
		.rdData(rdData),
		.rdHit(rdHit)
	);

	// ready lines leave flops in the slave, so every bus output is registered
	assign s_axi_awready = awReadyC;
	assign s_axi_wready = wReadyC;
	assign s_axi_arready = arReadyC;

	tcpr_prescaler #(.WIDTH(DIV_WIDTH)) u_presc (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.run(run_r),
		.divideSetting(divideSetting_r),
		.updateEvent(updateEvent),
		.tick(tick),
		.shadowSetting(shadowSetting)
	);

	// update fires when a tick finds the count at the reload value and no count write comes in the same cycle
	assign updateEvent = tick && (count_r == reload_r) && !wrReq.wrCount;

	// count step: software write wins over counting
	always_comb begin
		count_nxt = count_r;
		if (wrReq.wrCount)
			count_nxt = wrReq.data[CW-1:0];
		else if (updateEvent)
			count_nxt = '0;
		else if (tick)
			count_nxt = count_r + 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			count_r <= '0;
		else
			count_r <= count_nxt;
	end

	// divider, reload and enable registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			divideSetting_r <= '0;
			reload_r <= '0;
			run_r <= 1'b0;
		end else begin
			if (wrReq.wrDivider)
				divideSetting_r <= wrReq.data[DIV_WIDTH-1:0];
			if (wrReq.wrReload)
				reload_r <= wrReq.data[CW-1:0];
			if (wrReq.wrControl)
				run_r <= wrReq.data[CTRL_EN_BIT];
		end
	end

	// read mux; narrow bits above the field read zero
	always_comb begin
		rdData = RST_WORD;
		rdHit = 1'b1;
		case (rdAddr)
			OFS_COUNT: rdData[CW-1:0] = count_r;
			OFS_DIVIDER: rdData[DIV_WIDTH-1:0] = divideSetting_r;
			OFS_RELOAD: rdData[CW-1:0] = reload_r;
			OFS_CONTROL: rdData[CTRL_EN_BIT] = run_r;
			default: rdHit = 1'b0;
		endcase
	end

	// registered status outputs
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			updatePulse <= 1'b0;
			liveCount <= RST_WORD;
		end else begin
			updatePulse <= updateEvent;
			liveCount <= RST_WORD | 32'(count_nxt);
		end
	end
endmodule : tcpr_timer_core // tcpr_timer_core
`default_nettype wire

// *** verification/tb_top.sv ***
// Purpose: self-checking bench for the timer counting core
// Assumes: wide variant, master changes signals after rising edges
// Notes: ready lines read at the falling edge, where they have settled
`default_nettype none
module tb_top
	import tcpr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] awA = 8'h00, arA = 8'h00;
	logic [31:0] wD = 32'h0, rD, cnt, v, rb;
	logic [3:0] wS = 4'hF;
	logic awV = 1'b0, wV = 1'b0, bRdy = 1'b0, arV = 1'b0, rRdy = 1'b0;
	logic awR, wR, bV, arR, rV, upd;
	logic [1:0] bRsp, rRsp;
	int n_fail = 0, checked = 0, c;
	always #10 ref_clk = ~ref_clk;
	tcpr_timer_core #(.WIDE(1'b1)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD),
		.s_axi_wstrb(wS), .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bRsp),
		.s_axi_bvalid(bV), .s_axi_bready(bRdy), .s_axi_araddr(arA), .s_axi_arvalid(arV),
		.s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rRsp), .s_axi_rvalid(rV),
		.s_axi_rready(rRdy), .updatePulse(upd), .liveCount(cnt));
	// cycles between wraps: ticks per period times cycles per tick
	function automatic int period(int r, int p);
		return (r + 1) * (p + 1);
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	// address and data driven together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge ref_clk);
		awA <= a;
		wD <= d;
		awV <= 1'b1;
		wV <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge ref_clk);
			ta |= awV & awR;
			tw |= wV & wR;
			@(posedge ref_clk);
			if (ta) awV <= 1'b0;
			if (tw) wV <= 1'b0;
		end
		do @(negedge ref_clk); while (bV !== 1'b1);
		chk("bresp", {30'h0, er}, {30'h0, bRsp});
		// late ready keeps the response standing for a cycle
		@(posedge ref_clk) bRdy <= 1'b1;
		@(posedge ref_clk) bRdy <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		@(posedge ref_clk);
		arA <= a;
		arV <= 1'b1;
		do @(negedge ref_clk); while (arR !== 1'b1);
		@(posedge ref_clk) arV <= 1'b0;
		do @(negedge ref_clk); while (rV !== 1'b1);
		chk("rresp", {30'h0, er}, {30'h0, rRsp});
		d = rD;
		@(posedge ref_clk) rRdy <= 1'b1;
		@(posedge ref_clk) rRdy <= 1'b0;
	endtask
	task automatic gap(output int n);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (upd !== 1'b1);
	endtask
	task automatic summarize();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// watchdog, far beyond the few hundred cycles the tests take
	initial begin
		#100us;
		n_fail++;
		summarize();
	end
	initial begin
		void'($urandom(32'hCD58));
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		// reset values, last address unmapped
		for (int i = 0; i < 4; i++) begin
			rd(8'h24 + 8'(i * 4), i == 3 ? RESP_SLVERR : RESP_OKAY, v);
			chk("reset", 32'h0, v);
		end
		wr(8'h34, 32'h1, RESP_SLVERR);
		$display("test reset done");
		// corner then random words while stopped
		for (int i = 0; i < 4; i++) begin
			v = i == 0 ? 32'hFFFF_FFFF : $urandom;
			wr(OFS_RELOAD, v, RESP_OKAY);
			rd(OFS_RELOAD, RESP_OKAY, rb);
			chk("reload", v, rb);
			wr(OFS_COUNT, ~v, RESP_OKAY);
			chk("live count", ~v, cnt);
			rd(OFS_COUNT, RESP_OKAY, rb);
			chk("count", ~v, rb);
			wr(OFS_DIVIDER, v & 32'h0000_FFFF, RESP_OKAY);
			rd(OFS_DIVIDER, RESP_OKAY, rb);
			chk("divider", v & 32'h0000_FFFF, rb);
		end
		// a half-word strobe is refused and leaves the count alone
		wS <= 4'h3;
		wr(OFS_COUNT, 32'h5, RESP_SLVERR);
		wS <= 4'hF;
		chk("half word", ~v, cnt);
		rd(OFS_COUNT, RESP_OKAY, rb);
		chk("count kept", ~v, rb);
		$display("test readback done");
		// new divider waits until the first wrap loads it into the shadow
		wr(OFS_COUNT, 32'h0, RESP_OKAY);
		wr(OFS_RELOAD, 32'h3, RESP_OKAY);
		wr(OFS_DIVIDER, 32'h2, RESP_OKAY);
		wr(OFS_CONTROL, 32'h1 << CTRL_EN_BIT, RESP_OKAY);
		gap(c);
		chk("first wrap", 32'h1, 32'(c <= period(3, 0) + 4));
		gap(c);
		gap(c);
		chk("period", 32'(period(3, 2)), 32'(c));
		rd(OFS_COUNT, RESP_OKAY, v);
		chk("live", 32'h1, 32'(v <= 32'h3));
		$display("test run done");
		summarize();
	end
endmodule : tb_top
`default_nettype wire

// *** verification/tcpr_core_asserts.sv ***
// Purpose: port-level checks of the timer counting core
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every core instance
`default_nettype none
module tcpr_core_asserts
	import tcpr_pkg::*;
#(
	parameter bit WIDE = 1'b1
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// bus handshakes
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// status
	input wire logic [31:0] liveCount
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// count moves only by one, by wrap, or by a bus write
	a_count_step: assert property (
		!$rose(s_axi_bvalid) && liveCount != $past(liveCount)
		|-> liveCount == $past(liveCount) + 32'h1 || liveCount == 32'h0) else $error("count jumped");
	a_narrow_upper: assert property (!WIDE |-> liveCount[31:16] == 16'h0) else $error("upper bits set");
	a_err_data: assert property (
		s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0) else $error("error read data");
	a_r_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
	a_b_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("resp dropped");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted early");
	a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write accepted early");
endmodule : tcpr_core_asserts // tcpr_core_asserts

bind tcpr_timer_core tcpr_core_asserts #(.WIDE(WIDE)) u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .liveCount(liveCount));
`default_nettype wire
